// File: rtl/nipc_pkg.sv
// package: constants and helpers for the nested interrupt priority controller
package nipc_pkg;
  localparam int NV = 14;
  // apb word offsets
  localparam logic [7:0] A_PRIO0 = 8'h00;
  localparam logic [7:0] A_PRIO1 = 8'h04;
  localparam logic [7:0] A_PRIO2 = 8'h08;
  localparam logic [7:0] A_PRIO3 = 8'h0C;
  localparam logic [7:0] A_LEVEL = 8'h10;
  localparam logic [7:0] A_ENABLE = 8'h14;
  localparam logic [7:0] A_EXTSEL = 8'h18;
  localparam logic [7:0] A_PEND = 8'h1C;
  // level codes held as {upper, lower}
  localparam logic [1:0] LV0 = 2'h2;
  localparam logic [1:0] LV1 = 2'h1;
  localparam logic [1:0] LV2 = 2'h0;
  localparam logic [1:0] LV3 = 2'h3;
  // level bit positions inside the condition code image
  localparam int CC_UPPER = 5;
  localparam int CC_LOWER = 3;
  localparam logic [7:0] PRIO_RST = 8'hFF;
  localparam int PRIO_RO_REG = 3;
  localparam logic [7:0] PRIO_RO_MASK = 8'hF0;
  localparam logic [13:0] IEN_RST = 14'h0000;
  localparam logic [15:0] ESEL_RST = 16'h0000;
  // vector addresses
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_TOP = 16'hFFFA;
  // source classes
  localparam int EXT_LSB = 2;
  localparam logic [13:0] EXT_MASK = 14'h003C;
  localparam logic [13:0] HALT_MASK = 14'h00BC;

  typedef enum logic [2:0] {
    ST_BOOT = 3'h1,
    ST_IDLE = 3'h2,
    ST_ENTRY = 3'h4
  } nipc_state_t;

  // numeric urgency of a level code, 0 = main, 3 = most urgent
  function automatic logic [1:0] lv_rank(input logic [1:0] c);
    case (c)
      LV0: lv_rank = 2'h0;
      LV1: lv_rank = 2'h1;
      LV2: lv_rank = 2'h2;
      default: lv_rank = 2'h3;
    endcase
  endfunction : lv_rank
endpackage : nipc_pkg

// File: rtl/nipc_src_if.sv
// interface: pending latches toward the arbiter and acknowledges back
`timescale 1ns/1ps
`default_nettype none
interface nipc_src_if;
  logic [13:0] pend;
  logic [13:0] ack;
  modport ctl (input pend, output ack);
  modport src (output pend, input ack);
endinterface : nipc_src_if
`default_nettype wire

// File: rtl/nipc_src.sv
// module: request latches for external groups and peripherals
`timescale 1ns/1ps
`default_nettype none
module nipc_src import nipc_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sources
  input wire logic [15:0] ext_pins,
  input wire logic [15:0] ext_sel,
  input wire logic [13:0] periph_flag,
  input wire logic [13:0] periph_en,
  input wire logic [13:0] periph_clr,
  // toward the arbiter
  nipc_src_if.src bus
);
  logic [3:0] grp;
  logic [3:0] grp_q;
  logic [13:0] pend;
  logic [13:0] next_pend;
  logic [13:0] ext_evt;
  logic [13:0] keep;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_grp
      assign grp[g] = |(ext_pins[4*g +: 4] & ext_sel[4*g +: 4]);
    end
  endgenerate

  always_comb begin
    ext_evt = 14'({10'h000, grp & ~grp_q} << EXT_LSB);
    // a new event beats the clear in the same cycle
    keep = pend & ~(bus.ack & EXT_MASK) & ~(periph_clr & ~EXT_MASK);
    next_pend = keep | (ext_evt & EXT_MASK)
      | (periph_flag & periph_en & ~EXT_MASK);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 14'h0000;
      grp_q <= 4'h0;
    end else begin
      pend <= next_pend;
      grp_q <= grp;
    end
  end

  assign bus.pend = pend;

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> ((pend & $past(pend & ~bus.ack & ~periph_clr))
        == $past(pend & ~bus.ack & ~periph_clr));
  endproperty
  a_hold: assert property (p_hold) else $error("pending latch lost");
endmodule : nipc_src
`default_nettype wire

// File: rtl/nipc_top.sv
// module: nested interrupt priority controller with apb registers
`timescale 1ns/1ps
`default_nettype none
module nipc_top import nipc_pkg::*; (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // request sources
  input wire logic [15:0] ext_pins,
  input wire logic [13:0] periph_flag,
  input wire logic [13:0] periph_clr,
  // core events
  input wire logic cpu_boundary,
  input wire logic cpu_trap,
  input wire logic cpu_return_from_irq_instr,
  input wire logic [1:0] cpu_pop_level,
  input wire logic cpu_set_level,
  input wire logic [1:0] cpu_level_val,
  input wire logic cpu_wait,
  input wire logic cpu_halt,
  // toward the core
  output logic irq_take,
  output logic irq_stack,
  output logic [15:0] irq_vector,
  output logic [1:0] cur_level,
  output logic cpu_wake
);
  logic [7:0] prio [4];
  logic [7:0] next_prio [4];
  logic [13:0] ien;
  logic [13:0] next_ien;
  logic [15:0] esel;
  logic [15:0] next_esel;
  logic [1:0] next_level;
  logic trap_pend;
  logic next_trap;
  nipc_state_t state;
  nipc_state_t next_state;
  logic next_take;
  logic next_stack;
  logic [15:0] next_vec;
  logic next_wake;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic [31:0] rd_val;
  logic hit;
  logic acc;
  logic wr;
  logic [1:0] vprio [NV];
  logic [NV-1:0] cand;
  logic [NV-1:0] ack;
  logic win_ok;
  logic [3:0] win_idx;
  logic [1:0] win_rank;
  logic [1:0] win_code;
  logic take_mask;

  nipc_src_if src_bus ();

  nipc_src u_src (
    .pclk(pclk),
    .presetn(presetn),
    .ext_pins(ext_pins),
    .ext_sel(esel),
    .periph_flag(periph_flag),
    .periph_en(ien),
    .periph_clr(periph_clr),
    .bus(src_bus)
  );

  assign src_bus.ack = ack;

  // per-vector priority field and eligibility
  genvar gi;
  generate
    for (gi = 0; gi < NV; gi++) begin : g_vec
      assign vprio[gi] = prio[gi / 4][(gi % 4) * 2 +: 2];
      assign cand[gi] = src_bus.pend[gi] & ien[gi]
        & (lv_rank(vprio[gi]) > lv_rank(cur_level))
        & (~cpu_halt | HALT_MASK[gi]);
    end
  endgenerate

  // descending scan with >= leaves the lowest index on ties
  always_comb begin
    win_ok = 1'b0;
    win_idx = 4'h0;
    win_rank = 2'h0;
    for (int i = NV - 1; i >= 0; i--) begin
      if (cand[i] && (!win_ok || lv_rank(vprio[i]) >= win_rank)) begin
        win_ok = 1'b1;
        win_idx = 4'(i);
        win_rank = lv_rank(vprio[i]);
      end
    end
    win_code = vprio[win_idx];
  end

  // apb read decode
  always_comb begin
    rd_val = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == A_PRIO0) begin
      rd_val = 32'(prio[0]);
    end else if (paddr == A_PRIO1) begin
      rd_val = 32'(prio[1]);
    end else if (paddr == A_PRIO2) begin
      rd_val = 32'(prio[2]);
    end else if (paddr == A_PRIO3) begin
      rd_val = 32'(prio[3]);
    end else if (paddr == A_LEVEL) begin
      rd_val = (32'(cur_level[1]) << CC_UPPER) | (32'(cur_level[0]) << CC_LOWER);
    end else if (paddr == A_ENABLE) begin
      rd_val = 32'(ien);
    end else if (paddr == A_EXTSEL) begin
      rd_val = 32'(esel);
    end else if (paddr == A_PEND) begin
      rd_val = 32'(src_bus.pend);
    end else begin
      hit = 1'b0;
    end
  end

  // apb handshake: one wait state, data captured in the first access cycle
  always_comb begin
    acc = psel & penable;
    wr = acc & pready & pwrite;
    next_pready = acc & ~pready;
    next_pslverr = acc & ~pready & ~hit;
    next_prdata = prdata;
    if (acc && !pready) begin
      next_prdata = (pwrite || !hit) ? 32'h0000_0000 : rd_val;
    end
  end

  // register writes
  always_comb begin
    for (int r = 0; r < 4; r++) begin
      next_prio[r] = prio[r];
    end
    next_ien = ien;
    next_esel = esel;
    if (wr && pready && !pslverr) begin
      for (int r = 0; r < 4; r++) begin
        if (paddr == A_PRIO0 + 8'(r * 4)) begin
          for (int f = 0; f < 4; f++) begin
            if (pwdata[f * 2 +: 2] != LV0) begin
              next_prio[r][f * 2 +: 2] = pwdata[f * 2 +: 2];
            end
          end
        end
      end
      if (paddr == A_ENABLE) begin
        next_ien = pwdata[13:0];
      end
      if (paddr == A_EXTSEL) begin
        next_esel = pwdata[15:0];
      end
    end
    next_prio[PRIO_RO_REG] = next_prio[PRIO_RO_REG] | PRIO_RO_MASK;
  end

  // entry sequencing and level bits
  always_comb begin
    next_state = state;
    next_take = 1'b0;
    next_stack = irq_stack;
    next_vec = irq_vector;
    next_level = cur_level;
    next_trap = trap_pend | cpu_trap;
    ack = 14'h0000;
    take_mask = 1'b0;
    if (cpu_return_from_irq_instr) begin
      next_level = cpu_pop_level;
    end else if (cpu_set_level) begin
      next_level = cpu_level_val;
    end
    case (state)
      ST_BOOT: begin
        next_take = 1'b1;
        next_stack = 1'b0;
        next_vec = VEC_RESET;
        next_level = LV3;
        next_state = ST_IDLE;
      end
      ST_IDLE: begin
        // no entry while the core is itself rewriting the level
        if (cpu_boundary && !cpu_return_from_irq_instr && !cpu_set_level) begin
          if (trap_pend) begin
            next_take = 1'b1;
            next_stack = 1'b1;
            next_vec = VEC_TRAP;
            next_level = LV3;
            next_trap = cpu_trap;
            next_state = ST_ENTRY;
          end else if (win_ok) begin
            take_mask = 1'b1;
            next_take = 1'b1;
            next_stack = 1'b1;
            next_vec = VEC_TOP - 16'({win_idx, 1'b0});
            next_level = win_code;
            ack = EXT_MASK & (14'h0001 << win_idx);
            next_state = ST_ENTRY;
          end
        end
      end
      ST_ENTRY: begin
        // lets the acknowledged latch drop before the next decision
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_BOOT;
      end
    endcase
  end

  // wake request toward the clock control
  always_comb begin
    next_wake = (cpu_wait && ((|(src_bus.pend & ien)) || trap_pend))
      || (cpu_halt && ((|(src_bus.pend & ien & HALT_MASK)) || trap_pend));
  end

  // stack depth is the core's business: overrun passes silently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int r = 0; r < 4; r++) begin
        prio[r] <= PRIO_RST;
      end
      ien <= IEN_RST;
      esel <= ESEL_RST;
      state <= ST_BOOT;
      cur_level <= LV3;
      trap_pend <= 1'b0;
      irq_take <= 1'b0;
      irq_stack <= 1'b0;
      irq_vector <= VEC_RESET;
      cpu_wake <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      prio <= next_prio;
      ien <= next_ien;
      esel <= next_esel;
      state <= next_state;
      cur_level <= next_level;
      trap_pend <= next_trap;
      irq_take <= next_take;
      irq_stack <= next_stack;
      irq_vector <= next_vec;
      cpu_wake <= next_wake;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_trap_entry;
    irq_take && irq_vector == VEC_TRAP && irq_stack ##1 !irq_take;
  endsequence

  sequence s_boot_entry;
    irq_take && irq_vector == VEC_RESET && !irq_stack && cur_level == LV3;
  endsequence

  // anchored on the leave-boot step, so the edge that releases reset cannot start an attempt
  property p_boot;
    state == ST_BOOT ##1 state == ST_IDLE |-> s_boot_entry;
  endproperty
  a_boot: assert property (p_boot) else $error("boot entry wrong");

  property p_trap;
    state == ST_IDLE && trap_pend && cpu_boundary && !cpu_return_from_irq_instr && !cpu_set_level
      |=> s_trap_entry;
  endproperty
  a_trap: assert property (p_trap) else $error("trap not taken");

  property p_trap_lvl;
    irq_take && irq_vector == VEC_TRAP |-> cur_level == LV3;
  endproperty
  a_trap_lvl: assert property (p_trap_lvl) else $error("trap level not 3");

  property p_copy;
    take_mask && state == ST_IDLE |=> cur_level == $past(win_code) && irq_take;
  endproperty
  a_copy: assert property (p_copy) else $error("level not copied");

  property p_mask;
    take_mask |-> lv_rank(win_code) > lv_rank(cur_level) && ien[win_idx];
  endproperty
  a_mask: assert property (p_mask) else $error("masked source taken");

  property p_vec;
    take_mask |=> irq_vector == VEC_TOP - 16'({$past(win_idx), 1'b0}) ##1 !irq_take;
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");

  property p_return_from_irq_instr;
    cpu_return_from_irq_instr |=> cur_level == $past(cpu_pop_level);
  endproperty
  a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("return_from_irq_instr level wrong");

  property p_lv0_kept;
    wr && pready && !pslverr && paddr == A_PRIO0 && pwdata[1:0] == LV0
      |=> prio[0][1:0] == $past(prio[0][1:0]);
  endproperty
  a_lv0_kept: assert property (p_lv0_kept) else $error("level 0 stored");

  property p_halt_first;
    take_mask && cpu_halt |-> HALT_MASK[win_idx];
  endproperty
  a_halt_first: assert property (p_halt_first) else $error("halt exit source");

  property p_wake;
    cpu_wait && (|(src_bus.pend & ien)) |=> cpu_wake;
  endproperty
  a_wake: assert property (p_wake) else $error("wait not ended");
endmodule : nipc_top
`default_nettype wire

// File: dv/nipc_core_model.sv
// core model: instruction boundaries and a log of entries
`timescale 1ns/1ps
`default_nettype none
module nipc_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench control
  input wire logic run,
  input wire logic slow,
  // toward the controller
  output logic cpu_boundary,
  // from the controller
  input wire logic irq_take,
  input wire logic irq_stack,
  input wire logic [15:0] irq_vector,
  // entry log
  output logic [7:0] takes,
  output logic [15:0] last_vec,
  output logic last_stack
);
  logic [1:0] cnt;
  // slow mode ends an instruction only every fourth cycle
  assign cpu_boundary = run & (~slow | (cnt == 2'h3));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 2'h0;
      takes <= 8'h00;
      last_vec <= 16'h0000;
      last_stack <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      if (irq_take) begin
        takes <= takes + 8'h01;
        last_vec <= irq_vector;
        last_stack <= irq_stack;
      end
    end
  end
endmodule : nipc_core_model
`default_nettype wire

// File: dv/nested_interrupt_priority_controller_bench.sv
// bench: self-checking test of the nested interrupt priority controller
`timescale 1ns/1ps
`default_nettype none
module nested_interrupt_priority_controller_bench import nipc_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, irq_take, irq_stack, cpu_wake, last_stack, cpu_boundary;
  logic [15:0] ext_pins = 16'h0, irq_vector, last_vec;
  logic [13:0] periph_flag = 14'h0, periph_clr = 14'h0;
  logic cpu_trap = 1'b0, cpu_return_from_irq_instr = 1'b0, cpu_set_level = 1'b0, cpu_wait = 1'b0;
  logic cpu_halt = 1'b0, run = 1'b0, slow = 1'b0;
  logic [1:0] cpu_pop_level = 2'h0, cpu_level_val = 2'h0, cur_level;
  logic [7:0] takes;
  logic [7:0] sh [4];
  int num_errors = 0, total_checks = 0;
  always #12.5 pclk = ~pclk;
  nipc_top u_nipc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ext_pins, .periph_flag, .periph_clr, .cpu_boundary,
    .cpu_trap, .cpu_return_from_irq_instr, .cpu_pop_level, .cpu_set_level, .cpu_level_val, .cpu_wait,
    .cpu_halt, .irq_take, .irq_stack, .irq_vector, .cur_level, .cpu_wake);
  nipc_core_model u_nipc_core_model (.pclk, .presetn, .run, .slow, .cpu_boundary,
    .irq_take, .irq_stack, .irq_vector, .takes, .last_vec, .last_stack);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic setlv(input logic [1:0] v);
    @(posedge pclk);
    cpu_set_level <= 1'b1;
    cpu_level_val <= v;
    @(posedge pclk);
    cpu_set_level <= 1'b0;
    @(negedge pclk);
    chk("level set", v, cur_level);
  endtask : setlv
  task automatic setf(input int v, input logic [1:0] f);
    sh[v/4][2*(v%4)+:2] = f;
    apb(1'b1, 8'(4 * (v / 4)), {24'h0, sh[v/4]}, rd);
  endtask : setf
  // waits for one entry, then checks nothing else slips in behind it
  task automatic take(input logic [15:0] v, input logic [1:0] lv, input logic st);
    logic [7:0] t0;
    int n;
    t0 = takes;
    n = 0;
    @(posedge pclk);
    run <= 1'b1;
    slow <= 1'($urandom);
    while (takes === t0 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    @(posedge pclk);
    run <= 1'b0;
    repeat (4) @(negedge pclk);
    chk("vector", v, last_vec);
    chk("entry level", lv, cur_level);
    chk("stack", st, last_stack);
    chk("entries", t0 + 8'h01, takes);
  endtask : take
  function automatic logic [7:0] keep(input logic [7:0] o, input logic [7:0] n);
    keep = n;
    for (int i = 0; i < 8; i += 2)
      if (n[i+:2] == LV0) keep[i+:2] = o[i+:2];
  endfunction : keep
  function automatic int rk(input logic [1:0] c);
    rk = (c == LV0) ? 0 : (c == LV1) ? 1 : (c == LV2) ? 2 : 3;
  endfunction : rk
  function automatic logic [15:0] vec(input int n);
    vec = VEC_TOP - 16'(2 * n);
  endfunction : vec
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #1000000;
    num_errors++;
    final_report();
  end
  initial begin
    void'($urandom(95));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(negedge pclk);
    chk("boot count", 1, takes);
    chk("boot vector", VEC_RESET, last_vec);
    chk("boot stack", 0, last_stack);
    chk("boot level", LV3, cur_level);
    for (int r = 0; r < 4; r++) begin
      sh[r] = PRIO_RST;
      apb(1'b0, 8'(4 * r), 32'h0, rd);
      chk("prio reset", 32'hFF, rd);
    end
    apb(1'b0, 8'h20, 32'h0, rd);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    apb(1'b1, A_PRIO0, 32'hCF, rd);
    apb(1'b1, A_PRIO0, 32'h64, rd);
    apb(1'b0, A_PRIO0, 32'h0, rd);
    chk("prio keep", 32'h44, rd);
    sh[0] = 8'h44;
    repeat (8) begin
      int r;
      logic [7:0] d;
      r = $urandom % 4;
      d = 8'($urandom);
      sh[r] = keep(sh[r], d);
      apb(1'b1, 8'(4 * r), {24'h0, d}, rd);
      apb(1'b0, 8'(4 * r), 32'h0, rd);
      chk("prio rw", {24'h0, sh[r] | (r == PRIO_RO_REG ? PRIO_RO_MASK : 8'h00)}, rd);
    end
    $display("test registers done");
    apb(1'b1, A_ENABLE, 32'h3FFF, rd);
    cpu_wait <= 1'b1;
    repeat (6) begin
      int a, b, w;
      logic [1:0] fa, fb;
      a = 8 + $urandom % 6;
      b = 8 + (a - 7 + $urandom % 5) % 6;
      fa = 2'($urandom % 3);
      fb = 2'($urandom % 3);
      fa = (fa == LV0) ? LV3 : fa;
      fb = (fb == LV0) ? LV3 : fb;
      setf(a, fa);
      setf(b, fb);
      setlv(LV0);
      @(posedge pclk);
      periph_flag <= (14'h1 << a) | (14'h1 << b);
      repeat (3) @(negedge pclk);
      chk("wait wake", 1, cpu_wake);
      w = (rk(fa) > rk(fb) || (rk(fa) == rk(fb) && a < b)) ? a : b;
      take(vec(w), w == a ? fa : fb, 1'b1);
      @(posedge pclk);
      periph_flag <= 14'h0;
      @(posedge pclk);
      periph_clr <= 14'h3FFF;
      @(posedge pclk);
      periph_clr <= 14'h0;
      apb(1'b0, A_PEND, 32'h0, rd);
      chk("pend cleared", 0, rd);
    end
    $display("test arbitration done");
    cpu_wait <= 1'b0;
    setf(10, LV2);
    apb(1'b1, A_ENABLE, 32'h3BFF, rd);
    @(posedge pclk);
    periph_flag <= 14'h0400;
    apb(1'b0, A_PEND, 32'h0, rd);
    chk("pend disabled", 0, rd);
    apb(1'b1, A_ENABLE, 32'h3FFF, rd);
    setlv(LV2);
    @(posedge pclk);
    run <= 1'b1;
    repeat (6) @(negedge pclk);
    chk("no entry", 8'd7, takes);
    @(posedge pclk);
    run <= 1'b0;
    apb(1'b0, A_PEND, 32'h0, rd);
    chk("pend held", 32'h400, rd);
    setlv(LV1);
    take(vec(10), LV2, 1'b1);
    @(posedge pclk);
    periph_flag <= 14'h0;
    cpu_halt <= 1'b1;
    setf(7, LV1);
    setf(8, LV3);
    setlv(LV0);
    @(posedge pclk);
    periph_flag <= 14'h0100;
    repeat (3) @(negedge pclk);
    chk("halt asleep", 0, cpu_wake);
    @(posedge pclk);
    periph_flag <= 14'h0180;
    repeat (3) @(negedge pclk);
    chk("halt wake", 1, cpu_wake);
    take(vec(7), LV1, 1'b1);
    @(posedge pclk);
    cpu_halt <= 1'b0;
    take(vec(8), LV3, 1'b1);
    @(posedge pclk);
    periph_flag <= 14'h0;
    // peripheral latches outlive their flags: discard 7, 8 and 10 before the next test
    @(posedge pclk);
    periph_clr <= 14'h3FFF;
    @(posedge pclk);
    periph_clr <= 14'h0;
    apb(1'b0, A_PEND, 32'h0, rd);
    chk("pend discarded", 0, rd);
    $display("test halt done");
    setf(2, LV1);
    setlv(LV0);
    apb(1'b1, A_EXTSEL, 32'h0006, rd);
    ext_pins <= 16'h0001;
    apb(1'b0, A_PEND, 32'h0, rd);
    chk("unselected pin", 0, rd);
    ext_pins <= 16'h0005;
    take(vec(2), LV1, 1'b1);
    apb(1'b0, A_PEND, 32'h0, rd);
    chk("edge latch", 0, rd);
    cpu_return_from_irq_instr <= 1'b1;
    cpu_pop_level <= LV0;
    @(posedge pclk);
    cpu_return_from_irq_instr <= 1'b0;
    @(negedge pclk);
    chk("return level", LV0, cur_level);
    // level 0 is upper 1, lower 0: bit 5 set, bit 3 clear
    apb(1'b0, A_LEVEL, 32'h0, rd);
    chk("level image", 32'h20, rd);
    setlv(LV3);
    apb(1'b0, A_LEVEL, 32'h0, rd);
    chk("level image", 32'h28, rd);
    @(posedge pclk);
    cpu_trap <= 1'b1;
    @(posedge pclk);
    cpu_trap <= 1'b0;
    take(VEC_TRAP, LV3, 1'b1);
    $display("test entry done");
    final_report();
  end
endmodule : nested_interrupt_priority_controller_bench
`default_nettype wire
